// file: bps_map.svh
// Constants for the packet sequencer: opcodes, field positions, counts.
// Assumes inclusion by the package, design modules and bench.
`ifndef BPS_MAP_SVH
`define BPS_MAP_SVH
// Command codes on the host command port
`define BPS_OP_NOP        4'h0
`define BPS_OP_TX_POWER   4'h1
`define BPS_OP_WRITE_MEM  4'h2
`define BPS_OP_ROUTE      4'h3
`define BPS_OP_TX         4'h4
`define BPS_OP_RX         4'h5
`define BPS_OP_STATUS     4'h6
`define BPS_OP_CLEAR      4'h7
`define BPS_OP_RXBUF      4'h8
`define BPS_OP_READ_MEM   4'h9
`define BPS_OP_STANDBY    4'hA
// Flag bit positions
`define BPS_F_TX_COMPLETE_FLAG      0
`define BPS_F_RX_COMPLETE_FLAG      1
`define BPS_F_SYNC        2
`define BPS_F_CRC         3
`define BPS_F_TIMEOUT     4
`define BPS_NFLAGS        5
// Step counts with special meaning
`define BPS_STEPS_NONE    16'h0000
`define BPS_STEPS_CONT    16'hFFFF
// Sync match codes
`define BPS_SYNC_ERR      3'h0
`define BPS_SYNC_ADDR1    3'h1
// Cycles per timeout step and calibration time
`define BPS_STEP_NS       1000
`define BPS_CLK_NS        8
`define BPS_STEP_CYC      ((`BPS_STEP_NS + `BPS_CLK_NS - 1) / `BPS_CLK_NS)
`define BPS_CAL_NS        400
`define BPS_CAL_CYC       ((`BPS_CAL_NS + `BPS_CLK_NS - 1) / `BPS_CLK_NS)
`define BPS_MEM_DEPTH     256
`endif

// file: bps_pkg.sv
// Types shared by the packet sequencer modules.
// Assumes bps_map.svh for the constants.
`include "bps_map.svh"
package bps_pkg;
   // Host command
   typedef struct packed {
      logic       valid;
      logic [3:0] op;
      logic [7:0] arg0;
      logic [15:0] arg1;
   } bps_cmd_t;
   // Radio-side packet events
   typedef struct packed {
      logic       tx_end;
      logic       sync;
      logic       header;
      logic       rx_end;
      logic       crc_bad;
      logic       oversize;
      logic       abort;
      logic       sync_bad;
   } bps_evt_t;
   // Operating states
   typedef enum logic [2:0] {
      BPS_CAL, BPS_IDLE, BPS_TX, BPS_RX
   } bps_state_t;
endpackage : bps_pkg

// file: bps_step_timer.sv
// Timeout timer counting steps of a fixed cycle length.
// Assumes a synchronous active-low reset on the shared clock.
`timescale 1ns/1ps
`include "bps_map.svh"
module bps_step_timer (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Control
   input  wire logic        load_i,
   input  wire logic        stop_i,
   input  wire logic [15:0] steps_i,
   // Expiry pulse
   output logic             expire_o
);
   logic [15:0] steps;
   logic [7:0]  sub;
   logic        run;

   // Step counter, stops and reloads on command
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         steps    <= 16'h0000;
         sub      <= 8'h00;
         run      <= 1'b0;
         expire_o <= 1'b0;
      end else begin
         expire_o <= 1'b0;
         if (load_i) begin
            steps <= steps_i;
            sub   <= 8'(`BPS_STEP_CYC - 1);
            run   <= (steps_i != `BPS_STEPS_NONE);
         end else if (stop_i) begin
            run <= 1'b0;
         end else if (run) begin
            if (sub != 8'h00) begin
               sub <= sub - 8'h01;
            end else begin
               sub <= 8'(`BPS_STEP_CYC - 1);
               if (steps == 16'h0001) begin
                  run      <= 1'b0;
                  expire_o <= 1'b1;
               end
               steps <= steps - 16'h0001;
            end
         end
      end
   end
endmodule : bps_step_timer

// file: bps_sequencer.sv
// Packet transmit and receive sequencer driven by host commands.
// Assumes host commands and radio events are synchronous to clk_i.
//
// Function
// - Payload write stores bytes in the buffer from the given offset.
// - Transmit-complete flag rises at end of transmit, device then idle.
// - After send or transmit timeout the device returns idle by itself.
// - Transmit timeout armed only for nonzero step count; expiry flags, idles.
// - Status byte three bit 0 shows transmit finished; upper bits reserved.
// - Clear command resets only flags whose mask bit is one.
// - Receive-complete flag rises on every detected packet, valid or not.
// - Sync detection and CRC failure each raise their own flag.
// - Receive timeout flag rises when no packet arrives within the interval.
// - Each event line is the OR of its routed flags.
// - Step count zero: single receive, no timeout, idle after packet.
// - Step count all ones: continuous receive until a standby command.
// - Other counts: timed receive ends on expiry or packet.
// - Timed receive stops its timer once a packet is detected.
// - Report carries signal strength captured at sync detection.
// - Byte two bit 6 sync failure, bit 5 oversize, bit 7 reserved.
// - Byte two bit 4 CRC failure, bit 3 aborted packet.
// - Byte two bit 2 header, bit 1 receive done, bit 0 busy.
// - Byte four bits 2:0 give sync match code; rest reserved.
// - Buffer report returns last packet length and start offset.
// - After reset the device calibrates, idles and drops busy.
`timescale 1ns/1ps
`include "bps_map.svh"
module bps_sequencer (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   // Host command port
   input  wire bps_pkg::bps_cmd_t  cmd_i,
   input  wire logic [7:0]         wr_data_i,
   // Radio side
   input  wire bps_pkg::bps_evt_t  evt_i,
   input  wire logic [7:0]         rssi_i,
   input  wire logic [7:0]         rx_byte_i,
   input  wire logic               rx_byte_vld_i,
   // Host answers
   output logic [7:0]              rd_data_o,
   output logic                    rd_vld_o,
   output logic [7:0]              tx_power_o,
   output logic [7:0]              ramp_o,
   output logic [7:0]              sync_signal_strength_o,
   output logic [7:0]              status2_o,
   output logic [7:0]              status3_o,
   output logic [7:0]              status4_o,
   output logic [7:0]              rx_length_o,
   output logic [7:0]              rx_start_offset_o,
   output logic [`BPS_NFLAGS-1:0]  flags_o,
   // Pins
   output logic                    busy_o,
   output logic                    tx_active_o,
   output logic                    rx_active_o,
   output logic                    event_line_a_o,
   output logic                    event_line_b_o,
   output logic                    event_line_c_o
);
   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   bps_pkg::bps_state_t     state;
   logic [7:0]              mem [`BPS_MEM_DEPTH];
   logic [7:0]              wr_ptr;
   logic [7:0]              rd_ptr;
   logic [7:0]              rd_left;
   logic [7:0]              rx_ptr;
   logic [7:0]              rx_base;
   logic [7:0]              cal_cnt;
   logic                    cont_rx;
   logic                    got_pkt;
   logic                    tmr_load;
   logic                    tmr_stop;
   logic                    expire;
   logic [`BPS_NFLAGS-1:0]  flag_select_mask;
   logic [`BPS_NFLAGS-1:0]  route_a;
   logic [`BPS_NFLAGS-1:0]  route_b;
   logic [`BPS_NFLAGS-1:0]  route_c;
   logic [`BPS_NFLAGS-1:0]  flag_set;
   logic [`BPS_NFLAGS-1:0]  next_flags;
   logic                    is_cmd;
   logic                    mode_cmd;

   assign is_cmd   = cmd_i.valid;
   assign mode_cmd = is_cmd && (cmd_i.op == `BPS_OP_TX || cmd_i.op == `BPS_OP_RX
                     || cmd_i.op == `BPS_OP_STANDBY);
   assign tmr_load = is_cmd && state == bps_pkg::BPS_IDLE && (cmd_i.op == `BPS_OP_TX
                     || (cmd_i.op == `BPS_OP_RX && cmd_i.arg1 != `BPS_STEPS_CONT));
   assign tmr_stop = (state == bps_pkg::BPS_RX && evt_i.sync)
                     || state == bps_pkg::BPS_IDLE;

   // -----------------------------------------------------------------
   // Timeout timer
   // -----------------------------------------------------------------
   bps_step_timer u_timer (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .load_i   (tmr_load),
      .stop_i   (tmr_stop),
      .steps_i  (cmd_i.arg1),
      .expire_o (expire)
   );

   // -----------------------------------------------------------------
   // Operating state
   // -----------------------------------------------------------------
   // Calibration, idle, transmit and receive sequencing
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state   <= bps_pkg::BPS_CAL;
         cal_cnt <= 8'h00;
         cont_rx <= 1'b0;
         got_pkt <= 1'b0;
      end else begin
         case (state)
            bps_pkg::BPS_CAL: begin
               cal_cnt <= cal_cnt + 8'h01;
               if (cal_cnt == 8'(`BPS_CAL_CYC - 1))
                  state <= bps_pkg::BPS_IDLE;
            end
            bps_pkg::BPS_IDLE: begin
               if (is_cmd && cmd_i.op == `BPS_OP_TX) begin
                  state <= bps_pkg::BPS_TX;
               end else if (is_cmd && cmd_i.op == `BPS_OP_RX) begin
                  state   <= bps_pkg::BPS_RX;
                  cont_rx <= (cmd_i.arg1 == `BPS_STEPS_CONT);
                  got_pkt <= 1'b0;
               end
            end
            bps_pkg::BPS_TX: begin
               if (evt_i.tx_end || expire || (is_cmd && cmd_i.op == `BPS_OP_STANDBY))
                  state <= bps_pkg::BPS_IDLE;
            end
            bps_pkg::BPS_RX: begin
               if (evt_i.sync)
                  got_pkt <= 1'b1;
               if (is_cmd && cmd_i.op == `BPS_OP_STANDBY)
                  state <= bps_pkg::BPS_IDLE;
               else if (evt_i.rx_end && !cont_rx)
                  state <= bps_pkg::BPS_IDLE;
               else if (expire && !got_pkt)
                  state <= bps_pkg::BPS_IDLE;
            end
            default: state <= bps_pkg::BPS_IDLE;
         endcase
      end
   end

   // Activity and busy pins
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         busy_o      <= 1'b1;
         tx_active_o <= 1'b0;
         rx_active_o <= 1'b0;
      end else begin
         busy_o      <= (state == bps_pkg::BPS_CAL);
         tx_active_o <= (state == bps_pkg::BPS_TX);
         rx_active_o <= (state == bps_pkg::BPS_RX);
      end
   end

   // -----------------------------------------------------------------
   // Configuration
   // -----------------------------------------------------------------
   // Power, ramp and interrupt routing
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tx_power_o       <= 8'h00;
         ramp_o           <= 8'h00;
         flag_select_mask <= '0;
         route_a          <= '0;
         route_b          <= '0;
         route_c          <= '0;
      end else if (is_cmd && cmd_i.op == `BPS_OP_TX_POWER) begin
         tx_power_o <= cmd_i.arg0;
         ramp_o     <= cmd_i.arg1[7:0];
      end else if (is_cmd && cmd_i.op == `BPS_OP_ROUTE) begin
         flag_select_mask <= cmd_i.arg0[`BPS_NFLAGS-1:0];
         route_a          <= cmd_i.arg1[`BPS_NFLAGS-1:0];
         route_b          <= cmd_i.arg1[`BPS_NFLAGS+4:5];
         route_c          <= wr_data_i[`BPS_NFLAGS-1:0];
      end
   end

   // -----------------------------------------------------------------
   // Payload memory
   // -----------------------------------------------------------------
   // Host writes stream in from the offset; received bytes from rx base
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr  <= 8'h00;
         rx_ptr  <= 8'h00;
         rx_base <= 8'h00;
      end else begin
         if (is_cmd && cmd_i.op == `BPS_OP_WRITE_MEM) begin
            mem[cmd_i.arg0] <= wr_data_i;
            wr_ptr          <= cmd_i.arg0 + 8'h01;
         end else if (!is_cmd && cmd_i.op == `BPS_OP_WRITE_MEM
                      && cmd_i.arg1[8]) begin
            mem[wr_ptr] <= wr_data_i;
            wr_ptr      <= wr_ptr + 8'h01;
         end else if (state == bps_pkg::BPS_RX && rx_byte_vld_i) begin
            mem[rx_ptr] <= rx_byte_i;
            rx_ptr      <= rx_ptr + 8'h01;
         end
         if (is_cmd && cmd_i.op == `BPS_OP_RX) begin
            rx_base <= cmd_i.arg0;
            rx_ptr  <= cmd_i.arg0;
         end else if (state == bps_pkg::BPS_RX && evt_i.sync) begin
            rx_base <= rx_ptr;
         end
      end
   end

   // Buffer reads, one byte per cycle for the requested length
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rd_ptr    <= 8'h00;
         rd_left   <= 8'h00;
         rd_data_o <= 8'h00;
         rd_vld_o  <= 1'b0;
      end else if (is_cmd && cmd_i.op == `BPS_OP_READ_MEM) begin
         rd_ptr   <= cmd_i.arg0;
         rd_left  <= cmd_i.arg1[7:0];
         rd_vld_o <= 1'b0;
      end else if (rd_left != 8'h00) begin
         rd_data_o <= mem[rd_ptr];
         rd_vld_o  <= 1'b1;
         rd_ptr    <= rd_ptr + 8'h01;
         rd_left   <= rd_left - 8'h01;
      end else begin
         rd_vld_o <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Packet report and buffer report
   // -----------------------------------------------------------------
   // Status bytes; reserved positions held at zero
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sync_signal_strength_o <= 8'h00;
         status2_o              <= 8'h00;
         status3_o              <= 8'h00;
         status4_o              <= 8'h00;
         rx_length_o            <= 8'h00;
         rx_start_offset_o      <= 8'h00;
      end else begin
         status2_o[7] <= 1'b0;
         status3_o[7:1] <= 7'h00;
         status4_o[7:3] <= 5'h00;
         status2_o[0] <= (state == bps_pkg::BPS_TX)
                         || (state == bps_pkg::BPS_RX && got_pkt);
         if (mode_cmd && cmd_i.op != `BPS_OP_STANDBY) begin
            status2_o[6:1] <= 6'h00;
            status3_o[0]   <= 1'b0;
            status4_o[2:0] <= `BPS_SYNC_ERR;
         end else begin
            if (state == bps_pkg::BPS_TX && evt_i.tx_end)
               status3_o[0] <= 1'b1;
            if (state == bps_pkg::BPS_RX) begin
               if (evt_i.sync) begin
                  sync_signal_strength_o <= rssi_i;
                  status4_o[2:0]         <= `BPS_SYNC_ADDR1;
                  status2_o[6]           <= 1'b0;
               end
               if (evt_i.sync_bad) begin
                  status2_o[6]   <= 1'b1;
                  status4_o[2:0] <= `BPS_SYNC_ERR;
               end
               if (evt_i.oversize)
                  status2_o[5] <= 1'b1;
               if (evt_i.crc_bad)
                  status2_o[4] <= 1'b1;
               if (evt_i.header)
                  status2_o[2] <= 1'b1;
               if (evt_i.rx_end) begin
                  status2_o[1]      <= 1'b1;
                  rx_length_o       <= rx_ptr - rx_base;
                  rx_start_offset_o <= rx_base;
               end
            end
            if (evt_i.abort && state != bps_pkg::BPS_IDLE)
               status2_o[3] <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Interrupt flags and event lines
   // -----------------------------------------------------------------
   // Hardware events gated by the enable mask
   always_comb begin
      flag_set = '0;
      flag_set[`BPS_F_TX_COMPLETE_FLAG]  = state == bps_pkg::BPS_TX && evt_i.tx_end;
      flag_set[`BPS_F_RX_COMPLETE_FLAG]  = state == bps_pkg::BPS_RX && evt_i.rx_end;
      flag_set[`BPS_F_SYNC]    = state == bps_pkg::BPS_RX && evt_i.sync;
      flag_set[`BPS_F_CRC]     = state == bps_pkg::BPS_RX && evt_i.crc_bad;
      flag_set[`BPS_F_TIMEOUT] = expire && (state == bps_pkg::BPS_TX
                                 || (state == bps_pkg::BPS_RX && !got_pkt));
      flag_set = flag_set & flag_select_mask;
      next_flags = flags_o;
      if (is_cmd && cmd_i.op == `BPS_OP_CLEAR)
         next_flags = flags_o & ~cmd_i.arg1[`BPS_NFLAGS-1:0];
      next_flags = next_flags | flag_set;
   end

   // Flags, set wins over clear
   always_ff @(posedge clk_i) begin
      if (!rst_n_i)
         flags_o <= '0;
      else
         flags_o <= next_flags;
   end

   // Event lines from the next flag value
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         event_line_a_o <= 1'b0;
         event_line_b_o <= 1'b0;
         event_line_c_o <= 1'b0;
      end else begin
         event_line_a_o <= |(next_flags & route_a);
         event_line_b_o <= |(next_flags & route_b);
         event_line_c_o <= |(next_flags & route_c);
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   tx_end_idle_a: assert property (
      state == bps_pkg::BPS_TX && evt_i.tx_end |=> state == bps_pkg::BPS_IDLE)
      else $error("transmit end did not return to idle");
   tx_flag_a: assert property (
      state == bps_pkg::BPS_TX && evt_i.tx_end && flag_select_mask[`BPS_F_TX_COMPLETE_FLAG]
      |=> flags_o[`BPS_F_TX_COMPLETE_FLAG])
      else $error("transmit flag missing");
   clear_mask_a: assert property (
      is_cmd && cmd_i.op == `BPS_OP_CLEAR && flag_set == '0
      |=> flags_o == ($past(flags_o) & ~$past(cmd_i.arg1[`BPS_NFLAGS-1:0])))
      else $error("clear did not follow mask");
   cont_rx_stay_a: assert property (
      state == bps_pkg::BPS_RX && cont_rx && !is_cmd |=> state == bps_pkg::BPS_RX)
      else $error("continuous receive left by itself");
   rx_single_a: assert property (
      state == bps_pkg::BPS_RX && !cont_rx && evt_i.rx_end && !is_cmd
      |=> state == bps_pkg::BPS_IDLE)
      else $error("single receive did not idle");
   line_a_or_a: assert property (
      ##1 event_line_a_o == |($past(next_flags) & $past(route_a)))
      else $error("event line a wrong");
   sync_rssi_a: assert property (
      state == bps_pkg::BPS_RX && evt_i.sync && !mode_cmd
      |=> sync_signal_strength_o == $past(rssi_i))
      else $error("signal strength not captured");
   reserved_zero_a: assert property (
      ##1 status2_o[7] == 1'b0 && status3_o[7:1] == 7'h00 && status4_o[7:3] == 5'h00)
      else $error("reserved bits not zero");
   busy_cal_a: assert property (
      state == bps_pkg::BPS_IDLE |=> !busy_o)
      else $error("busy high in idle");

   tx_seen_c:   cover property (state == bps_pkg::BPS_TX ##1 state == bps_pkg::BPS_IDLE);
   rx_seen_c:   cover property (state == bps_pkg::BPS_RX && evt_i.rx_end);
   tmo_seen_c:  cover property (expire);
   clear_seen_c: cover property (is_cmd && cmd_i.op == `BPS_OP_CLEAR && |flags_o);
endmodule : bps_sequencer

// file: bps_host_model.sv
// Host model issuing sequencer commands on the command port.
// Assumes the bench calls its tasks; drives at time zero, then only at falling edges.
`timescale 1ns/1ps
`include "bps_map.svh"
module bps_host_model (
   // Clock
   input  wire logic        clk_i,
   // Command port
   output bps_pkg::bps_cmd_t cmd_o,
   output logic [7:0]       wr_data_o
);
   // Idle port at time zero
   initial begin
      cmd_o     = '0;
      wr_data_o = 8'h00;
   end
   // Released op, arg0 and data show inverted values, arg1 zero, never the last ones
   task automatic drop(input logic [7:0] wd);
      @(negedge clk_i);
      cmd_o     <= '{1'b0, ~cmd_o.op, ~cmd_o.arg0, 16'h0000};
      wr_data_o <= ~wd;
   endtask : drop
   // One command, valid for a single cycle
   task automatic send(input logic [3:0] op, input logic [7:0] a0,
                       input logic [15:0] a1, input logic [7:0] wd);
      @(negedge clk_i);
      cmd_o     <= '{1'b1, op, a0, a1};
      wr_data_o <= wd;
      drop(wd);
   endtask : send
   // Payload burst; first byte is the protocol header
   task automatic write_mem(input logic [7:0] off, input logic [7:0] d[$]);
      @(negedge clk_i);
      cmd_o     <= '{1'b1, `BPS_OP_WRITE_MEM, off, 16'h0000};
      wr_data_o <= d[0];
      for (int i = 1; i < d.size(); i++) begin
         @(negedge clk_i);
         cmd_o     <= '{1'b0, `BPS_OP_WRITE_MEM, off, 16'h0100};
         wr_data_o <= d[i];
      end
      drop(d[d.size()-1]);
   endtask : write_mem
endmodule : bps_host_model

// file: tb_ble_packet_txrx_sequencer.sv
// Self-checking bench for the packet sequencer.
// Assumes bps_pkg and bps_host_model are compiled first.
`timescale 1ns/1ps
`include "bps_map.svh"
module tb_ble_packet_txrx_sequencer;
   logic clk_i = 1'b0;
   logic rst_n_i;
   bps_pkg::bps_cmd_t cmd_i;
   logic [7:0] wr_data_i, rssi_i, rx_byte_i, rd_data_o, tx_power_o, ramp_o, sss_o;
   logic [7:0] status2_o, status3_o, status4_o, rx_length_o, rx_start_offset_o;
   bps_pkg::bps_evt_t evt_i;
   logic rx_byte_vld_i, rd_vld_o, busy_o, tx_active_o, rx_active_o, ev_a, ev_b, ev_c;
   logic [`BPS_NFLAGS-1:0] flags_o;
   logic [7:0] exp_q[$], pay_q[$];
   logic [7:0] exp_rssi;
   int fails = 0, num_checks = 0, seed;

   // 125 MHz clock
   always #4 clk_i = ~clk_i;

   bps_host_model u_host (.clk_i(clk_i), .cmd_o(cmd_i), .wr_data_o(wr_data_i));
   bps_sequencer u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i),
      .wr_data_i(wr_data_i), .evt_i(evt_i), .rssi_i(rssi_i), .rx_byte_i(rx_byte_i),
      .rx_byte_vld_i(rx_byte_vld_i), .rd_data_o(rd_data_o), .rd_vld_o(rd_vld_o),
      .tx_power_o(tx_power_o), .ramp_o(ramp_o), .sync_signal_strength_o(sss_o),
      .status2_o(status2_o), .status3_o(status3_o), .status4_o(status4_o),
      .rx_length_o(rx_length_o), .rx_start_offset_o(rx_start_offset_o),
      .flags_o(flags_o), .busy_o(busy_o), .tx_active_o(tx_active_o),
      .rx_active_o(rx_active_o), .event_line_a_o(ev_a), .event_line_b_o(ev_b),
      .event_line_c_o(ev_c));

   // Counts, verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   // One comparison
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Read data against the oldest noted byte
   always @(negedge clk_i) begin
      if (rd_vld_o === 1'b1) begin
         if (exp_q.size() == 0)
            chk("extra read byte", 16'h0000, 16'h0001);
         else
            chk("read byte", {8'h00, exp_q.pop_front()}, {8'h00, rd_data_o});
      end
   end
   // Radio event pulse of one cycle
   task automatic pulse(input logic [7:0] e);
      @(negedge clk_i);
      evt_i = bps_pkg::bps_evt_t'(e);
      @(negedge clk_i);
      evt_i = '0;
   endtask : pulse
   // Received packet: sync, header, n bytes, end
   task automatic rx_pkt(input logic bad, input int n, input int gap);
      pay_q.delete();
      rssi_i   = $random(seed);
      exp_rssi = rssi_i;
      pulse(8'h40);
      rssi_i = ~rssi_i;
      pulse(8'h20);
      repeat (gap) @(negedge clk_i);
      for (int i = 0; i < n; i++) begin
         rx_byte_i     = $random(seed);
         rx_byte_vld_i = 1'b1;
         pay_q.push_back(rx_byte_i);
         @(negedge clk_i);
      end
      rx_byte_vld_i = 1'b0;
      rx_byte_i     = ~rx_byte_i;
      pulse(bad ? 8'h1F : 8'h10);
      repeat (3) @(negedge clk_i);
   endtask : rx_pkt
   // Note expected bytes, read them back, wait for all
   task automatic read_back(input logic [7:0] off, input logic [7:0] len);
      foreach (pay_q[i]) exp_q.push_back(pay_q[i]);
      u_host.send(`BPS_OP_READ_MEM, off, {8'h00, len}, 8'h00);
      for (int i = 0; i < 600 && exp_q.size() > 0; i++) @(negedge clk_i);
      chk("bytes left", 16'h0000, 16'(exp_q.size()));
   endtask : read_back
   // Clear all flags and check them gone
   task automatic clear_all();
      u_host.send(`BPS_OP_CLEAR, 8'h00, 16'h001F, 8'h00);
      repeat (2) @(negedge clk_i);
      chk("flags cleared", 16'h0000, 16'(flags_o));
   endtask : clear_all
   // Timeout run with one step and no packet
   task automatic tmo(input logic [3:0] op);
      u_host.send(op, 8'h00, 16'h0001, 8'h00);
      repeat (100) @(negedge clk_i);
      chk("no early timeout", 16'h0000, 16'(flags_o[`BPS_F_TIMEOUT]));
      repeat (40) @(negedge clk_i);
      chk("timeout flag", 16'h0001, 16'(flags_o[`BPS_F_TIMEOUT]));
      chk("idle after timeout", 16'h0000, {tx_active_o, rx_active_o});
      clear_all();
   endtask : tmo

   // Main sequence
   initial begin
      seed = 32'h9D55137E;
      rst_n_i = 1'b0;
      evt_i = '0;
      rssi_i = 8'h00;
      rx_byte_i = 8'h00;
      rx_byte_vld_i = 1'b0;
      repeat (10) @(negedge clk_i);
      chk("busy in reset", 16'h0001, 16'(busy_o));
      rst_n_i = 1'b1;
      for (int i = 0; i < 200 && busy_o !== 1'b0; i++) @(negedge clk_i);
      chk("busy after cal", 16'h0000, 16'(busy_o));
      $display("test reset done");
      u_host.send(`BPS_OP_TX_POWER, 8'h5A, 16'h00C3, 8'h00);
      u_host.send(`BPS_OP_ROUTE, 8'h1F, 16'h003F, 8'h0E);
      @(negedge clk_i);
      chk("power ramp", 16'h5AC3, {tx_power_o, ramp_o});
      u_host.send(`BPS_OP_TX, 8'h00, `BPS_STEPS_NONE, 8'h00);
      repeat (40) @(negedge clk_i);
      chk("tx without timeout", 16'h0001, 16'(tx_active_o));
      pulse(8'h80);
      repeat (3) @(negedge clk_i);
      chk("tx flags", 16'h0001, 16'(flags_o));
      chk("tx idle", 16'h0000, 16'(tx_active_o));
      chk("status3", 16'h0001, 16'(status3_o));
      chk("event lines", 16'h0006, {ev_a, ev_b, ev_c});
      u_host.send(`BPS_OP_CLEAR, 8'h00, 16'h0002, 8'h00);
      repeat (2) @(negedge clk_i);
      chk("masked clear", 16'h0001, 16'(flags_o));
      clear_all();
      chk("lines low", 16'h0000, {ev_a, ev_b, ev_c});
      tmo(`BPS_OP_TX);
      $display("test transmit done");
      for (int k = 0; k < 2; k++) begin
         u_host.send(`BPS_OP_RX, 8'h10, `BPS_STEPS_NONE, 8'h00);
         repeat (20) @(negedge clk_i);
         rx_pkt(k[0], 4 + k, 0);
         chk("rx flags", k ? 16'h000E : 16'h0006, 16'(flags_o));
         chk("status2", k ? 16'h007E : 16'h0006, 16'(status2_o));
         chk("status4", k ? 16'h0000 : 16'h0001, 16'(status4_o));
         chk("strength", {8'h00, exp_rssi}, {8'h00, sss_o});
         chk("rx length", 16'(4 + k), 16'(rx_length_o));
         chk("rx offset", 16'h0010, 16'(rx_start_offset_o));
         chk("single idle", 16'h0000, 16'(rx_active_o));
         chk("line c", 16'h0001, 16'(ev_c));
         read_back(rx_start_offset_o, rx_length_o);
         clear_all();
      end
      $display("test single receive done");
      u_host.send(`BPS_OP_RX, 8'h00, `BPS_STEPS_CONT, 8'h00);
      rx_pkt(1'b0, 3, 0);
      rx_pkt(1'b0, 2, 0);
      chk("continuous stays", 16'h0001, 16'(rx_active_o));
      chk("continuous flags", 16'h0006, 16'(flags_o));
      chk("rx report", 16'h0302, {rx_start_offset_o, rx_length_o});
      u_host.send(`BPS_OP_STANDBY, 8'h00, 16'h0000, 8'h00);
      repeat (2) @(negedge clk_i);
      chk("standby leaves", 16'h0000, 16'(rx_active_o));
      clear_all();
      u_host.send(`BPS_OP_RX, 8'h00, 16'h0001, 8'h00);
      repeat (10) @(negedge clk_i);
      rx_pkt(1'b0, 2, 200);
      chk("timer stopped", 16'h0006, 16'(flags_o));
      chk("timed idle", 16'h0000, 16'(rx_active_o));
      clear_all();
      tmo(`BPS_OP_RX);
      $display("test timed receive done");
      pay_q = '{8'h02, $random(seed), $random(seed), 8'hFF};
      u_host.write_mem(8'h40, pay_q);
      read_back(8'h40, 8'h04);
      $display("test payload memory done");
      stop_test();
   end
   // Watchdog well past the expected run length
   initial begin
      #100000;
      fails++;
      $display("[FAIL] watchdog expected end seen hang");
      stop_test();
   end
endmodule : tb_ble_packet_txrx_sequencer
